// ---- hw/pkecs_defs.svh ----
// Register map, field positions and reset values of the engine control block.
// Assumes word addressing on the register port: one index per register.
`ifndef PKECS_DEFS_SVH
`define PKECS_DEFS_SVH

// Register indices
`define PKECS_IDX_RAM_LO 12'hA00
`define PKECS_IDX_RAM_HI 12'hABF
`define PKECS_IDX_CTRL 12'hB01
`define PKECS_IDX_STAT 12'hB02
`define PKECS_IDX_MASK 12'hB03
`define PKECS_IDX_PC 12'hB05

// Control field positions
`define PKECS_CB_MONT 9
`define PKECS_CB_SRST 10
`define PKECS_CB_IE 11
`define PKECS_CB_GO 12
`define PKECS_CB_ECC 13

// Bits that software may hold in the control register
`define PKECS_CTRL_STATIC 16'h2BBF
`define PKECS_CTRL_RST 16'h0000

// Status field positions
`define PKECS_SB_DPERR 1
`define PKECS_SB_IRQ 12
`define PKECS_SB_OB 13
`define PKECS_SB_DONE 14
`define PKECS_STAT_RST 16'h0000
`define PKECS_MASK_RST 16'h0000

// Sticky event slots
`define PKECS_EV_DPERR 0
`define PKECS_EV_OB 1
`define PKECS_EV_DONE 2
`define PKECS_EV_NUM 3

`endif

// ---- hw/pkecs_pkg.sv ----
// Types shared by the engine control block.
// Assumes pkecs_defs.svh is available on the include path.
package pkecs_pkg;

	// Sequencer states
	typedef enum logic [1:0] {
		PKECS_SQ_IDLE,
		PKECS_SQ_RUN,
		PKECS_SQ_CLEAR
	} pkecs_seq_state_t;

endpackage

// ---- hw/pkecs_sticky.sv ----
// One sticky status flag: set by a hardware event, cleared by software.
// Assumes set and clear arrive synchronous to clk_sys_i.
`timescale 1ns/1ps

module pkecs_sticky (
	input wire logic clk_sys_i, // System clock
	input wire logic sys_rst_i, // Synchronous reset, active high
	input wire logic set_i, // Event pulse
	input wire logic clr_i, // Clear request
	output logic q_o // Flag value
);

	logic q_q; // Flag register
	logic q_d; // Next flag value

	// Set wins over a clear in the same cycle
	always_comb begin
		q_d = set_i | (q_q & ~clr_i);
	end

	// Register only
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			q_q <= 1'b0;
		end else begin
			q_q <= q_d;
		end
	end

	assign q_o = q_q;

endmodule

// ---- hw/pkecs_sequencer.sv ----
// Microcode program counter, run state and operand memory clear walk.
// Assumes an external decoder reports jumps of the addressed instruction.
`timescale 1ns/1ps

module pkecs_sequencer import pkecs_pkg::*; #(
	parameter int PCW = 8, // Program counter width
	parameter int MEMW = 64 // Words swept by the clear walk
) (
	input wire logic clk_sys_i, // System clock
	input wire logic sys_rst_i, // Synchronous reset, active high
	input wire logic sw_rst_i, // Software reset pulse
	input wire logic go_i, // Run trigger pulse
	input wire logic pc_wr_i, // Host load of the counter
	input wire logic [PCW-1:0] pc_wdata_i, // Host counter value
	input wire logic jump_i, // Current instruction jumps
	input wire logic [PCW-1:0] jump_tgt_i, // Jump target
	output logic [PCW-1:0] pc_o, // Program counter
	output logic run_o, // Executing microcode
	output logic clear_o, // Clear walk active
	output logic [$clog2(MEMW)-1:0] clr_addr_o, // Word being cleared
	output logic done_o // Stop on jump to zero, pulse
);

	localparam int CW = $clog2(MEMW);

	initial begin
		if (PCW < 1 || MEMW < 2) begin
			$error("pkecs_sequencer: bad parameters");
		end
	end

	pkecs_seq_state_t st_q, st_d; // Run state
	logic [PCW-1:0] pc_q, pc_d; // Program counter
	logic [CW-1:0] ca_q, ca_d; // Clear walk address
	logic done_q, done_d; // Stop pulse

	// Next state of the sequencer
	always_comb begin
		st_d = st_q;
		pc_d = pc_q;
		ca_d = ca_q;
		done_d = 1'b0;
		if (sw_rst_i) begin
			// R2 counter to zero
			pc_d = '0;
			// R3 halt execution at once
			// R4 run clear routine
			st_d = PKECS_SQ_CLEAR;
			ca_d = '0;
		end else begin
			case (st_q)
				PKECS_SQ_IDLE: begin
					if (pc_wr_i) begin
						pc_d = pc_wdata_i;
					end
					// R7 start at counter
					if (go_i) begin
						st_d = PKECS_SQ_RUN;
					end
				end
				PKECS_SQ_RUN: begin
					if (jump_i) begin
						pc_d = jump_tgt_i;
						// R7 stop on zero
						if (jump_tgt_i == '0) begin
							st_d = PKECS_SQ_IDLE;
							done_d = 1'b1;
						end
					end else begin
						pc_d = pc_q + 1'b1;
					end
				end
				PKECS_SQ_CLEAR: begin
					// Sweep every operand word once
					if (ca_q == CW'(MEMW - 1)) begin
						st_d = PKECS_SQ_IDLE;
					end else begin
						ca_d = ca_q + 1'b1;
					end
				end
				default: begin
					st_d = PKECS_SQ_IDLE;
				end
			endcase
		end
	end

	// Register only
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			st_q <= PKECS_SQ_IDLE;
			pc_q <= '0;
			ca_q <= '0;
			done_q <= 1'b0;
		end else begin
			st_q <= st_d;
			pc_q <= pc_d;
			ca_q <= ca_d;
			done_q <= done_d;
		end
	end

	assign pc_o = pc_q;
	assign run_o = (st_q == PKECS_SQ_RUN);
	assign clear_o = (st_q == PKECS_SQ_CLEAR);
	assign clr_addr_o = ca_q;
	assign done_o = done_q;

	// Stop on a jump to location zero
	stop_zero_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R7
		(run_o && jump_i && jump_tgt_i == '0 && !sw_rst_i) |=> (!run_o && done_o && pc_o == '0))
		else $error("run did not stop on jump to zero");

endmodule

// ---- hw/pkecs_engine_ctrl.sv ----
// Control and status register bank of the public-key engine.
// Assumes a host on a plain register port, word indices, read data a cycle later.
// Functional notes
// R1: Bit 9 picks Montgomery factor computation
// R2: Bit 10 resets registers, counter to zero
// R3: Software reset halts execution, drops interrupt
// R4: Software reset runs operand memory clear walk
// R5: Bit 11 gates the interrupt output
// R6: Interrupt flag sets regardless of enable
// R7: Bit 12 runs microcode until jump zero
// R8: Operand RAM accesses ignored while running
// R9: Host touches only status while running; control and mask writes still take effect while running
// R10: Bit 13 selects elliptic curve mode
// R11: Host writes zero to bits 14-15
// R12: Errors set a status bit
// R13: Jump to zero sets completion bit
// R14: Any status write clears status
// R15: Run and reset bits self-clear
// R16: Unused control bits read zero
// R17: Reset beats run in same write
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "pkecs_defs.svh"

module pkecs_engine_ctrl import pkecs_pkg::*; #(
	parameter int PCW = 8, // Program counter width
	parameter int MEMW = 64 // Operand words cleared by reset walk
) (
	input wire logic clk_sys_i, // System clock, 10 MHz
	input wire logic sys_rst_i, // Synchronous reset, active high
	input wire logic [11:0] reg_addr_i, // Register index
	input wire logic [31:0] reg_wdata_i, // Write data
	input wire logic reg_we_i, // Write strobe
	input wire logic reg_re_i, // Read strobe
	output logic [31:0] reg_rdata_o, // Read data, cycle after strobe
	output logic ram_wr_o, // Operand RAM write strobe
	output logic ram_rd_o, // Operand RAM read strobe
	input wire logic [31:0] ram_rdata_i, // Operand RAM read data
	input wire logic dp_err_i, // Datapath error pulse
	input wire logic ucode_jump_i, // Current instruction jumps
	input wire logic [PCW-1:0] ucode_target_i, // Jump target
	output logic [PCW-1:0] ucode_pc_o, // Program counter
	output logic engine_run_o, // Executing microcode
	output logic mem_clr_we_o, // Clear walk write strobe
	output logic [$clog2(MEMW)-1:0] mem_clr_addr_o, // Clear walk address
	output logic mont_cross_factor_select_o, // Montgomery factor select
	output logic ecc_mode_o, // Elliptic curve mode
	output logic [8:0] ctrl_low_o, // Lower control fields
	output logic irq_o // Interrupt, active high level
);

	initial begin
		if (PCW < 1 || PCW > 16 || MEMW < 2) begin
			$error("pkecs_engine_ctrl: bad parameters");
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address decode

	logic sel_ctrl; // Control register hit
	logic sel_stat; // Status register hit
	logic sel_mask; // Mask register hit
	logic sel_pc; // Program counter hit
	logic sel_ram; // Operand RAM window hit
	logic acc; // Any access
	logic busy; // Engine not idle

	always_comb begin
		sel_ctrl = (reg_addr_i == `PKECS_IDX_CTRL);
		sel_stat = (reg_addr_i == `PKECS_IDX_STAT);
		sel_mask = (reg_addr_i == `PKECS_IDX_MASK);
		sel_pc = (reg_addr_i == `PKECS_IDX_PC);
		sel_ram = (reg_addr_i >= `PKECS_IDX_RAM_LO) && (reg_addr_i <= `PKECS_IDX_RAM_HI);
		acc = reg_we_i | reg_re_i;
	end

	////////////////////////////////////////////////////////////////////////
	// Control register and dynamic pulses

	logic [15:0] ctrl_q, ctrl_d; // Static control bits
	logic [15:0] mask_q, mask_d; // Interrupt mask
	logic go_q, go_d; // Run trigger pulse
	logic srst_q, srst_d; // Software reset pulse
	logic ctrl_wr; // Host writes control
	logic wr_srst; // Write asks for reset

	always_comb begin
		ctrl_wr = reg_we_i & sel_ctrl;
		wr_srst = ctrl_wr & reg_wdata_i[`PKECS_CB_SRST];
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		// R15 pulses last one cycle
		go_d = 1'b0;
		srst_d = 1'b0;
		if (wr_srst) begin
			// R2 registers to initial values
			ctrl_d = `PKECS_CTRL_RST;
			mask_d = `PKECS_MASK_RST;
			srst_d = 1'b1;
		end else begin
			if (ctrl_wr) begin
				// R16 unused bits never stored
				ctrl_d = reg_wdata_i[15:0] & `PKECS_CTRL_STATIC;
				// R17 reset suppresses run
				go_d = reg_wdata_i[`PKECS_CB_GO];
			end
			if (reg_we_i & sel_mask) begin
				mask_d = reg_wdata_i[15:0];
			end
		end
	end

	// Register only
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			ctrl_q <= `PKECS_CTRL_RST;
			mask_q <= `PKECS_MASK_RST;
			go_q <= 1'b0;
			srst_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			mask_q <= mask_d;
			go_q <= go_d;
			srst_q <= srst_d;
		end
	end

	// R1 factor select
	assign mont_cross_factor_select_o = ctrl_q[`PKECS_CB_MONT];
	// R10 curve or RSA
	assign ecc_mode_o = ctrl_q[`PKECS_CB_ECC];
	assign ctrl_low_o = ctrl_q[8:0];

	////////////////////////////////////////////////////////////////////////
	// Sequencer

	logic clear_act; // Clear walk running
	logic seq_done; // Stop on jump to zero
	logic seq_run; // Executing microcode

	pkecs_sequencer #(
		.PCW(PCW),
		.MEMW(MEMW)
	) u_seq (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.sw_rst_i(srst_q),
		.go_i(go_q),
		.pc_wr_i(reg_we_i & sel_pc),
		.pc_wdata_i(reg_wdata_i[PCW-1:0]),
		.jump_i(ucode_jump_i),
		.jump_tgt_i(ucode_target_i),
		.pc_o(ucode_pc_o),
		.run_o(seq_run),
		.clear_o(clear_act),
		.clr_addr_o(mem_clr_addr_o),
		.done_o(seq_done)
	);

	assign engine_run_o = seq_run;
	assign busy = seq_run | clear_act;
	// R4 clear via routine
	assign mem_clr_we_o = clear_act;

	// R8 RAM ignored while busy
	assign ram_wr_o = reg_we_i & sel_ram & ~busy;
	assign ram_rd_o = reg_re_i & sel_ram & ~busy;

	////////////////////////////////////////////////////////////////////////
	// Status flags and interrupt

	logic [`PKECS_EV_NUM-1:0] ev_set; // Event pulses
	logic [`PKECS_EV_NUM-1:0] ev_q; // Sticky flags
	logic stat_clr; // Clear all flags
	logic ob_ev; // Unmapped access
	logic [15:0] stat_v; // Status word
	logic irq_pend; // Unmasked flag set

	always_comb begin
		ob_ev = acc & ~(sel_ctrl | sel_stat | sel_mask | sel_pc | sel_ram);
		// R12 errors set flags
		ev_set[`PKECS_EV_DPERR] = dp_err_i;
		ev_set[`PKECS_EV_OB] = ob_ev;
		// R13 completion flag
		ev_set[`PKECS_EV_DONE] = seq_done;
		// R14 any write clears; R3 reset drops interrupt
		stat_clr = (reg_we_i & sel_stat) | wr_srst;
		stat_v = `PKECS_STAT_RST;
		stat_v[`PKECS_SB_DPERR] = ev_q[`PKECS_EV_DPERR];
		stat_v[`PKECS_SB_OB] = ev_q[`PKECS_EV_OB];
		stat_v[`PKECS_SB_DONE] = ev_q[`PKECS_EV_DONE];
		// R6 flag ignores enable
		irq_pend = |(stat_v & mask_q);
		stat_v[`PKECS_SB_IRQ] = irq_pend;
	end

	// One sticky flag per event
	genvar gi;
	generate
		for (gi = 0; gi < `PKECS_EV_NUM; gi++) begin : g_ev
			pkecs_sticky u_flag (
				.clk_sys_i(clk_sys_i),
				.sys_rst_i(sys_rst_i),
				.set_i(ev_set[gi]),
				.clr_i(stat_clr),
				.q_o(ev_q[gi])
			);
		end
	endgenerate

	// R5 global enable gate
	assign irq_o = ctrl_q[`PKECS_CB_IE] & irq_pend;

	////////////////////////////////////////////////////////////////////////
	// Read data

	logic [31:0] rdata_q, rdata_d; // Read data register

	always_comb begin
		rdata_d = 32'h0000_0000;
		if (reg_re_i) begin
			if (sel_ctrl) begin
				// R16 dynamic and unused read zero
				rdata_d[15:0] = ctrl_q;
			end else if (sel_stat) begin
				rdata_d[15:0] = stat_v;
			end else if (sel_mask) begin
				rdata_d[15:0] = mask_q;
			end else if (sel_pc) begin
				rdata_d[PCW-1:0] = ucode_pc_o;
			end else if (ram_rd_o) begin
				rdata_d = ram_rdata_i;
			end
		end
	end

	// Register only
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_o = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_wr_both;
		ctrl_wr && reg_wdata_i[`PKECS_CB_SRST] && reg_wdata_i[`PKECS_CB_GO];
	endsequence

	sequence s_reset_settle;
		srst_q && !go_q ##1 (!seq_run && ucode_pc_o == '0);
	endsequence

	// A fresh pulse is only legal when the previous cycle wrote control again
	pulse_clear_a: assert property ((go_q || srst_q) |=> // R15
		((!go_q && !srst_q) || $past(ctrl_wr)))
		else $error("dynamic control bit did not self-clear");

	reset_wins_a: assert property (s_wr_both |=> s_reset_settle) // R17
		else $error("run started despite software reset");

	reset_effect_a: assert property (wr_srst |=> (ctrl_q == `PKECS_CTRL_RST && !irq_o)) // R2
		else $error("software reset left state behind");

	reset_clear_a: assert property (srst_q |=> clear_act [*2]) // R4
		else $error("clear walk not started by reset");

	ie_gate_a: assert property (!ctrl_q[`PKECS_CB_IE] |-> !irq_o) // R5
		else $error("interrupt driven while disabled");

	// Unmasked error raises the flag, whatever the global enable holds
	irq_flag_a: assert property ((dp_err_i && mask_q[`PKECS_SB_DPERR] && !wr_srst && // R6
		!(reg_we_i && sel_mask)) |=> stat_v[`PKECS_SB_IRQ])
		else $error("interrupt flag not set");

	ram_block_a: assert property (busy |-> (!ram_wr_o && !ram_rd_o)) // R8
		else $error("RAM access passed while busy");

	// Each error source lands in its own flag
	err_flag_a: assert property ((dp_err_i || ob_ev) |=> // R12
		((stat_v[`PKECS_SB_DPERR] || !$past(dp_err_i)) && (stat_v[`PKECS_SB_OB] || !$past(ob_ev))))
		else $error("error not flagged");

	// Completion flag follows the stop pulse by one edge
	done_flag_a: assert property (seq_done |=> stat_v[`PKECS_SB_DONE]) // R13
		else $error("completion not flagged");

	stat_wipe_a: assert property ((reg_we_i && sel_stat && !dp_err_i && !seq_done) |=> (stat_v == 16'h0000)) // R14
		else $error("status write did not clear");

	unused_zero_a: assert property ((reg_re_i && sel_ctrl) |=> (reg_rdata_o[15:14] == 2'h0 && !reg_rdata_o[6] && !reg_rdata_o[12] && !reg_rdata_o[10])) // R16
		else $error("unused control bit read nonzero");

	mont_sel_a: assert property ((ctrl_wr && !wr_srst) |=> (mont_cross_factor_select_o == $past(reg_wdata_i[`PKECS_CB_MONT]))) // R1
		else $error("factor select not updated");

	go_start_a: assert property ((go_q && !srst_q && !busy) |=> seq_run) // R7
		else $error("run trigger did not start execution");

endmodule

// ---- testbench/pkecs_ucode_model.sv ----
// Far side model: microcode decoder and operand RAM of the engine.
// Assumes jump is sampled only while the engine runs.
`timescale 1ns/1ps

module pkecs_ucode_model #(
	parameter int PCW = 8 // Counter width
) (
	input wire logic clk_sys_i, // System clock
	input wire logic [PCW-1:0] pc_i, // Program counter
	input wire logic run_i, // Engine running
	input wire logic [PCW-1:0] stop_pc_i, // Address of stop jump
	output logic jump_o, // Instruction jumps
	output logic [PCW-1:0] target_o, // Jump target
	input wire logic [11:0] addr_i, // Host index
	input wire logic [31:0] wdata_i, // Host data
	input wire logic wr_i, // RAM write strobe
	input wire logic rd_i, // RAM read strobe
	output logic [31:0] rdata_o // RAM read data
);
	logic [31:0] mem_q [0:191]; // Operand words
	logic [7:0] idx; // Offset in window
	logic [7:0] cnt_q = 8'h00; // Idle noise source

	assign idx = 8'(addr_i - 12'hA00);
	// Stop jump to zero; noise while idle
	assign jump_o = run_i ? (pc_i == stop_pc_i) : cnt_q[0];
	assign target_o = run_i ? '0 : PCW'(cnt_q);
	// Data only under read strobe, else changing
	assign rdata_o = rd_i ? mem_q[idx] : ~{4{cnt_q}};

	// RAM store and noise counter
	always_ff @(posedge clk_sys_i) begin
		cnt_q <= cnt_q + 8'h01;
		if (wr_i) begin
			mem_q[idx] <= wdata_i;
		end
	end
endmodule

// ---- testbench/pkecs_engine_ctrl_bench.sv ----
// Self-checking bench of the engine control and status bank.
// Assumes the far side model file is compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module pkecs_engine_ctrl_bench;
	localparam int PCW = 8; // Counter width
	localparam int MEMW = 4; // Short clear walk
	logic clk_sys_i = 1'b0; // Clock
	logic sys_rst_i = 1'b1; // Reset
	logic [11:0] reg_addr_i = 12'h000; // Index
	logic [31:0] reg_wdata_i = 32'h0; // Write data
	logic reg_we_i = 1'b0; // Write strobe
	logic reg_re_i = 1'b0; // Read strobe
	logic dp_err_i = 1'b0; // Error pulse
	logic [PCW-1:0] stop_pc = 8'h28; // Stop address
	logic [31:0] reg_rdata_o, ram_rdata_i; // Read paths
	logic ram_wr_o, ram_rd_o, jump, run, clr_we, mont, ecc, irq_o; // Outputs
	logic [PCW-1:0] target, pc; // Sequencer
	logic [1:0] clr_addr; // Clear walk address
	logic [8:0] ctrl_low; // Lower fields
	int n_fail = 0; // Mismatches
	int n_compared = 0; // Comparisons

	pkecs_engine_ctrl #(.PCW(PCW), .MEMW(MEMW)) dut_u (.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
		.ram_wr_o(ram_wr_o), .ram_rd_o(ram_rd_o), .ram_rdata_i(ram_rdata_i),
		.dp_err_i(dp_err_i), .ucode_jump_i(jump), .ucode_target_i(target),
		.ucode_pc_o(pc), .engine_run_o(run), .mem_clr_we_o(clr_we),
		.mem_clr_addr_o(clr_addr), .mont_cross_factor_select_o(mont), .ecc_mode_o(ecc),
		.ctrl_low_o(ctrl_low), .irq_o(irq_o));

	pkecs_ucode_model #(.PCW(PCW)) far_u (.clk_sys_i(clk_sys_i), .pc_i(pc), .run_i(run),
		.stop_pc_i(stop_pc), .jump_o(jump), .target_o(target), .addr_i(reg_addr_i),
		.wdata_i(reg_wdata_i), .wr_i(ram_wr_o), .rd_i(ram_rd_o), .rdata_o(ram_rdata_i));

	// Clock, 100 ns period
	initial begin
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus tasks
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_we_i <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_re_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_re_i <= 1'b0;
		@(negedge clk_sys_i);
		`CHK(reg_rdata_o, e)
	endtask

	// Bounded wait on the run state
	task automatic wait_run(input logic v);
		int i;
		for (i = 0; i < 300 && run !== v; i++) begin
			@(negedge clk_sys_i);
		end
		`CHK(run, v)
	endtask

	task automatic err_pulse;
		@(posedge clk_sys_i);
		dp_err_i <= 1'b1;
		@(posedge clk_sys_i);
		dp_err_i <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_ctrl;
		rd(12'hB01, 32'h0);
		rd(12'hB03, 32'h0);
		rd(12'hB05, 32'h0);
		wr(12'hB01, 32'h2BFF);
		@(negedge clk_sys_i);
		`CHK({mont, ecc, ctrl_low}, 11'h7BF) // fields out
		rd(12'hB01, 32'h2BBF); // reserved bit reads zero
		wr(12'hB01, 32'h0);
		@(negedge clk_sys_i);
		`CHK({mont, ecc}, 2'h0) // cleared
		$display("t_ctrl done");
	endtask

	task automatic t_run;
		wr(12'hA05, 32'h1234);
		wr(12'hB03, 32'h4000);
		wr(12'hB05, 32'h5);
		wr(12'hB01, 32'h1800);
		wait_run(1'b1); // run starts
		@(posedge clk_sys_i);
		reg_addr_i <= 12'hA05;
		reg_wdata_i <= 32'hDEAD;
		reg_we_i <= 1'b1;
		@(negedge clk_sys_i);
		`CHK(ram_wr_o, 1'b0) // RAM write ignored
		@(posedge clk_sys_i);
		reg_we_i <= 1'b0;
		rd(12'hB02, 32'h0);
		rd(12'hA05, 32'h0); // RAM read ignored
		wait_run(1'b0);
		// Done flag lands one edge after the stop
		@(negedge clk_sys_i);
		`CHK({pc, irq_o}, 9'h001) // stop and irq
		rd(12'hB02, 32'h5000); // done flag
		rd(12'hB01, 32'h0800); // run bit self-clears
		rd(12'hA05, 32'h1234); // old word kept
		$display("t_run done");
	endtask

	task automatic t_irq;
		wr(12'hB01, 32'h0);
		@(negedge clk_sys_i);
		`CHK(irq_o, 1'b0) // output held low
		rd(12'hB02, 32'h5000); // flag despite enable
		wr(12'hB01, 32'h0800);
		@(negedge clk_sys_i);
		`CHK(irq_o, 1'b1) // enabled
		wr(12'hB02, 32'hFFFF);
		@(negedge clk_sys_i);
		`CHK(irq_o, 1'b0) // clear drops irq
		rd(12'hB02, 32'h0); // any write clears
		$display("t_irq done");
	endtask

	task automatic t_err;
		wr(12'hB03, 32'h0002);
		err_pulse();
		rd(12'hB02, 32'h1002); // error bit
		`CHK(irq_o, 1'b1) // error raises irq
		rd(12'hB00, 32'h0);
		rd(12'hB02, 32'h3002); // out of bounds bit
		wr(12'hB02, 32'h0);
		$display("t_err done");
	endtask

	task automatic t_srst;
		int i;
		stop_pc = 8'hC8;
		wr(12'hB05, 32'h5);
		wr(12'hB01, 32'h1800);
		wait_run(1'b1);
		err_pulse();
		@(negedge clk_sys_i);
		`CHK(irq_o, 1'b1) // pending irq
		wr(12'hB01, 32'h1C00);
		@(negedge clk_sys_i);
		`CHK(irq_o, 1'b0) // irq dropped
		for (i = 0; i < 10 && clr_we !== 1'b1; i++) begin
			@(negedge clk_sys_i);
		end
		`CHK({run, pc}, 9'h000) // halted, counter zero
		for (i = 0; i < MEMW; i++) begin
			`CHK({clr_we, clr_addr}, {1'b1, 2'(i)}) // clear walk
			@(negedge clk_sys_i);
		end
		`CHK(clr_we, 1'b0) // walk length
		repeat (20) @(negedge clk_sys_i);
		`CHK(run, 1'b0) // reset beats run
		rd(12'hB01, 32'h0); // control reset
		rd(12'hB03, 32'h0); // mask reset
		rd(12'hB02, 32'h0); // status reset
		$display("t_srst done");
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Verdict
	task automatic test_done;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Watchdog well beyond the sequence length
	initial begin
		repeat (5000) @(posedge clk_sys_i);
		n_fail++;
		test_done();
	end

	// Main sequence
	initial begin
		repeat (10) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		t_ctrl();
		t_run();
		t_irq();
		t_err();
		t_srst();
		test_done();
	end
endmodule
